/* src/pmcs_consts.vh */
// Constants for the power monitor conversion setup block
// Assumes a single 20 MHz clock and the host register port of pmcs_top
`ifndef PMCS_CONSTS_VH
`define PMCS_CONSTS_VH

`define PMCS_ADDR_DEV_SETUP   8'h00
`define PMCS_ADDR_CONV_SETUP  8'h01
`define PMCS_DEV_SETUP_RST    16'h0000
`define PMCS_CONV_SETUP_RST   16'hfb68

`define PMCS_BIT_SOFT_RST     15
`define PMCS_DLY_HI           13
`define PMCS_DLY_LO           6
`define PMCS_BIT_SPAN         4
`define PMCS_MODE_HI          15
`define PMCS_MODE_CONT        15
`define PMCS_MODE_EN_HI       14
`define PMCS_MODE_EN_LO       12
`define PMCS_BUS_CT_HI        11
`define PMCS_BUS_CT_LO        9
`define PMCS_SH_CT_HI         8
`define PMCS_SH_CT_LO         6
`define PMCS_TMP_CT_HI        5
`define PMCS_TMP_CT_LO        3
`define PMCS_AVG_HI           2
`define PMCS_AVG_LO           0

`define PMCS_CLK_PERIOD_NS    50
`define PMCS_DLY_STEP_US      2000
`define PMCS_CT0_US           50
`define PMCS_CT1_US           84
`define PMCS_CT2_US           150
`define PMCS_CT3_US           280
`define PMCS_CT4_US           540
`define PMCS_CT5_US           1052
`define PMCS_CT6_US           2074
`define PMCS_CT7_US           4120

`define PMCS_AVG_SH0          4'h0
`define PMCS_AVG_SH1          4'h2
`define PMCS_AVG_SH2          4'h4
`define PMCS_AVG_SH3          4'h6
`define PMCS_AVG_SH4          4'h7
`define PMCS_AVG_SH5          4'h8
`define PMCS_AVG_SH6          4'h9
`define PMCS_AVG_SH7          4'ha

`define PMCS_CH_BUS           2'h0
`define PMCS_CH_SHUNT         2'h1
`define PMCS_CH_TEMP          2'h2
`define PMCS_TMR_W            24
`define PMCS_ACC_W            26

`endif

/* src/pmcs_cycle_timer.v */
// Down-counting cycle timer used for delay steps and conversions
// Assumes loaded counts of at least one; done pulses when the count expires
`include "pmcs_consts.vh"

module pmcs_cycle_timer (
    input  wire                    i_clock,
    input  wire                    i_rst_n,
    input  wire                    i_clear,
    input  wire                    i_load,
    input  wire [`PMCS_TMR_W-1:0]  i_count,
    output wire                    o_done
);

    reg [`PMCS_TMR_W-1:0] count;

    // Done while the last remaining cycle is counted
    assign o_done = (count == {{(`PMCS_TMR_W-1){1'b0}}, 1'b1});

    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count <= {`PMCS_TMR_W{1'b0}};
        else if (i_clear)
            count <= {`PMCS_TMR_W{1'b0}};
        else if (i_load)
            count <= i_count;
        else if (count != {`PMCS_TMR_W{1'b0}})
            count <= count - {{(`PMCS_TMR_W-1){1'b0}}, 1'b1};
    end

endmodule // pmcs_cycle_timer

/* src/pmcs_top.v */
// Setup registers and conversion sequencer of the power monitor
// Assumes the host port and converter sample are on the same clock
`include "pmcs_consts.vh"

module pmcs_top #(
    parameter CYCLES_PER_US   = 1000 / `PMCS_CLK_PERIOD_NS,
    parameter DLY_STEP_CYCLES = `PMCS_DLY_STEP_US * (1000 / `PMCS_CLK_PERIOD_NS)
) (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_reg_wr,
    input  wire [7:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    input  wire [15:0] i_adc_sample,
    output reg  [15:0] o_reg_rdata,
    output reg         o_shunt_span_sel,
    output reg         o_conv_start,
    output reg         o_conv_active,
    output reg  [1:0]  o_conv_chan,
    output reg         o_result_update,
    output wire [15:0] o_bus_volt_result,
    output wire [15:0] o_shunt_volt_result,
    output wire [15:0] o_temp_result
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_CONV  = 2'h2;

    reg        soft_rst;
    reg [7:0]  start_delay_steps;
    reg [15:0] conv_setup;
    reg        start_req;
    reg        abort;
    reg [1:0]  state;
    reg [7:0]  steps_left;
    reg [10:0] samp_cnt;
    reg        tmr_load;
    reg [`PMCS_TMR_W-1:0] tmr_count;
    reg [`PMCS_ACC_W-1:0] acc [0:2];
    reg [15:0] res [0:2];
    wire       tmr_done;

    wire [15:0] dev_rst_val = `PMCS_DEV_SETUP_RST;
    wire       wr_dev  = i_reg_wr && (i_reg_addr == `PMCS_ADDR_DEV_SETUP);
    wire       wr_conv = i_reg_wr && (i_reg_addr == `PMCS_ADDR_CONV_SETUP);

    // Mode decode: top bit continuous, low bits channel enables
    wire       mode_cont = conv_setup[`PMCS_MODE_CONT];
    wire [2:0] chan_en   = conv_setup[`PMCS_MODE_EN_HI:`PMCS_MODE_EN_LO];
    wire       shutdown  = (chan_en == 3'h0);

    function [31:0] ct_us;
        input [2:0] code;
        begin
            case (code)
                3'h0:    ct_us = `PMCS_CT0_US;
                3'h1:    ct_us = `PMCS_CT1_US;
                3'h2:    ct_us = `PMCS_CT2_US;
                3'h3:    ct_us = `PMCS_CT3_US;
                3'h4:    ct_us = `PMCS_CT4_US;
                3'h5:    ct_us = `PMCS_CT5_US;
                3'h6:    ct_us = `PMCS_CT6_US;
                default: ct_us = `PMCS_CT7_US;
            endcase
        end
    endfunction

    function [3:0] avg_shift;
        input [2:0] code;
        begin
            case (code)
                3'h0:    avg_shift = `PMCS_AVG_SH0;
                3'h1:    avg_shift = `PMCS_AVG_SH1;
                3'h2:    avg_shift = `PMCS_AVG_SH2;
                3'h3:    avg_shift = `PMCS_AVG_SH3;
                3'h4:    avg_shift = `PMCS_AVG_SH4;
                3'h5:    avg_shift = `PMCS_AVG_SH5;
                3'h6:    avg_shift = `PMCS_AVG_SH6;
                default: avg_shift = `PMCS_AVG_SH7;
            endcase
        end
    endfunction

    // Channel order bus, shunt, temperature
    wire [1:0] first_chan = chan_en[0] ? `PMCS_CH_BUS :
                            chan_en[1] ? `PMCS_CH_SHUNT : `PMCS_CH_TEMP;
    reg  [1:0] next_chan;
    reg        last_chan;
    always @*
    begin
        next_chan = `PMCS_CH_TEMP;
        last_chan = 1'b1;
        if (o_conv_chan == `PMCS_CH_BUS && chan_en[1])
        begin
            next_chan = `PMCS_CH_SHUNT;
            last_chan = 1'b0;
        end
        else if (o_conv_chan != `PMCS_CH_TEMP && chan_en[2])
        begin
            next_chan = `PMCS_CH_TEMP;
            last_chan = 1'b0;
        end
    end

    reg [2:0] ct_sel;
    always @*
    begin
        case (next_chan)
            `PMCS_CH_BUS:   ct_sel = conv_setup[`PMCS_BUS_CT_HI:`PMCS_BUS_CT_LO];
            `PMCS_CH_SHUNT: ct_sel = conv_setup[`PMCS_SH_CT_HI:`PMCS_SH_CT_LO];
            default:        ct_sel = conv_setup[`PMCS_TMP_CT_HI:`PMCS_TMP_CT_LO];
        endcase
    end
    reg [2:0] ct_first;
    always @*
    begin
        case (first_chan)
            `PMCS_CH_BUS:   ct_first = conv_setup[`PMCS_BUS_CT_HI:`PMCS_BUS_CT_LO];
            `PMCS_CH_SHUNT: ct_first = conv_setup[`PMCS_SH_CT_HI:`PMCS_SH_CT_LO];
            default:        ct_first = conv_setup[`PMCS_TMP_CT_HI:`PMCS_TMP_CT_LO];
        endcase
    end

    wire [31:0] next_cyc  = ct_us(ct_sel) * CYCLES_PER_US - 1;
    wire [31:0] first_cyc = ct_us(ct_first) * CYCLES_PER_US - 1;
    wire [31:0] step_cyc  = DLY_STEP_CYCLES - 1;
    wire [3:0]  sh        = avg_shift(conv_setup[`PMCS_AVG_HI:`PMCS_AVG_LO]);
    wire [10:0] avg_last  = (11'h001 << sh) - 11'h001;
    wire        take      = (state == ST_CONV) && tmr_done;
    wire        run_done  = take && last_chan && (samp_cnt == avg_last);

    // Host registers; a soft reset returns both to defaults next cycle
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            soft_rst          <= 1'b0;
            start_delay_steps <= 8'h00;
            o_shunt_span_sel  <= 1'b0;
            conv_setup        <= `PMCS_CONV_SETUP_RST;
            abort             <= 1'b0;
            o_reg_rdata       <= 16'h0000;
        end
        else if (soft_rst)
        begin
            soft_rst          <= 1'b0;
            start_delay_steps <= dev_rst_val[`PMCS_DLY_HI:`PMCS_DLY_LO];
            o_shunt_span_sel  <= 1'b0;
            conv_setup        <= `PMCS_CONV_SETUP_RST;
            abort             <= 1'b0;
            o_reg_rdata       <= 16'h0000;
        end
        else
        begin
            abort <= wr_conv;
            if (wr_dev)
            begin
                soft_rst          <= i_reg_wdata[`PMCS_BIT_SOFT_RST];
                start_delay_steps <= i_reg_wdata[`PMCS_DLY_HI:`PMCS_DLY_LO];
                o_shunt_span_sel  <= i_reg_wdata[`PMCS_BIT_SPAN];
            end
            if (wr_conv)
                conv_setup <= i_reg_wdata;
            if (i_reg_addr == `PMCS_ADDR_DEV_SETUP)
            begin
                o_reg_rdata <= 16'h0000;
                o_reg_rdata[`PMCS_DLY_HI:`PMCS_DLY_LO] <= start_delay_steps;
                o_reg_rdata[`PMCS_BIT_SPAN] <= o_shunt_span_sel;
            end
            else if (i_reg_addr == `PMCS_ADDR_CONV_SETUP)
                o_reg_rdata <= conv_setup;
            else
                o_reg_rdata <= 16'h0000;
        end
    end

    // Sequencer: start request, start delay, channel conversions
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state           <= ST_IDLE;
            start_req       <= 1'b1;
            steps_left      <= 8'h00;
            samp_cnt        <= 11'h000;
            tmr_load        <= 1'b0;
            tmr_count       <= {`PMCS_TMR_W{1'b0}};
            o_conv_start    <= 1'b0;
            o_conv_active   <= 1'b0;
            o_conv_chan     <= `PMCS_CH_BUS;
            o_result_update <= 1'b0;
        end
        else if (soft_rst || abort)
        begin
            state           <= ST_IDLE;
            start_req       <= 1'b1;
            steps_left      <= 8'h00;
            samp_cnt        <= 11'h000;
            tmr_load        <= 1'b0;
            tmr_count       <= {`PMCS_TMR_W{1'b0}};
            o_conv_start    <= 1'b0;
            o_conv_active   <= 1'b0;
            o_conv_chan     <= `PMCS_CH_BUS;
            o_result_update <= 1'b0;
        end
        else
        begin
            tmr_load        <= 1'b0;
            o_conv_start    <= 1'b0;
            o_result_update <= run_done;
            case (state)
                ST_IDLE:
                begin
                    if (start_req && !shutdown)
                    begin
                        start_req <= 1'b0;
                        if (start_delay_steps != 8'h00)
                        begin
                            state      <= ST_DELAY;
                            steps_left <= start_delay_steps;
                            tmr_load   <= 1'b1;
                            tmr_count  <= step_cyc[`PMCS_TMR_W-1:0];
                        end
                        else
                        begin
                            state         <= ST_CONV;
                            o_conv_chan   <= first_chan;
                            o_conv_start  <= 1'b1;
                            o_conv_active <= 1'b1;
                            tmr_load      <= 1'b1;
                            tmr_count     <= first_cyc[`PMCS_TMR_W-1:0];
                        end
                    end
                end
                ST_DELAY:
                begin
                    if (tmr_done)
                    begin
                        steps_left <= steps_left - 8'h01;
                        tmr_load   <= 1'b1;
                        if (steps_left == 8'h01)
                        begin
                            state         <= ST_CONV;
                            o_conv_chan   <= first_chan;
                            o_conv_start  <= 1'b1;
                            o_conv_active <= 1'b1;
                            tmr_count     <= first_cyc[`PMCS_TMR_W-1:0];
                        end
                        else
                            tmr_count <= step_cyc[`PMCS_TMR_W-1:0];
                    end
                end
                ST_CONV:
                begin
                    if (take && !last_chan)
                    begin
                        o_conv_chan  <= next_chan;
                        o_conv_start <= 1'b1;
                        tmr_load     <= 1'b1;
                        tmr_count    <= next_cyc[`PMCS_TMR_W-1:0];
                    end
                    else if (take && (!run_done || mode_cont))
                    begin
                        samp_cnt     <= run_done ? 11'h000 : samp_cnt + 11'h001;
                        o_conv_chan  <= first_chan;
                        o_conv_start <= 1'b1;
                        tmr_load     <= 1'b1;
                        tmr_count    <= first_cyc[`PMCS_TMR_W-1:0];
                    end
                    else if (take)
                    begin
                        samp_cnt      <= 11'h000;
                        state         <= ST_IDLE;
                        o_conv_active <= 1'b0;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Per-channel sum of samples and published average
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_chan
            wire                   hit = take && (o_conv_chan == g);
            wire [`PMCS_ACC_W-1:0] sum = acc[g] + (hit ?
                {{(`PMCS_ACC_W-16){i_adc_sample[15]}}, i_adc_sample} :
                {`PMCS_ACC_W{1'b0}});
            wire [`PMCS_ACC_W-1:0] sample_count_sel = $signed(sum) >>> sh;
            always @(posedge i_clock or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    acc[g] <= {`PMCS_ACC_W{1'b0}};
                    res[g] <= 16'h0000;
                end
                else if (soft_rst || abort)
                begin
                    acc[g] <= {`PMCS_ACC_W{1'b0}};
                    res[g] <= soft_rst ? 16'h0000 : res[g];
                end
                else if (run_done)
                begin
                    acc[g] <= {`PMCS_ACC_W{1'b0}};
                    if (chan_en[g])
                        res[g] <= sample_count_sel[15:0];
                end
                else if (hit)
                    acc[g] <= sum;
            end
        end
    endgenerate

    assign o_bus_volt_result   = res[0];
    assign o_shunt_volt_result = res[1];
    assign o_temp_result       = res[2];

    pmcs_cycle_timer u_timer (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_clear (soft_rst || abort),
        .i_load  (tmr_load),
        .i_count (tmr_count),
        .o_done  (tmr_done)
    );

endmodule // pmcs_top

/* verification/pmcs_top_sva.sv */
// Concurrent checks on the ports of pmcs_top
// Assumes it is bound into pmcs_top and handed its parameters
module pmcs_top_sva #(
    parameter CYCLES_PER_US   = 20,
    parameter DLY_STEP_CYCLES = 40000
) (
    input wire        i_clock,
    input wire        i_rst_n,
    input wire        i_reg_wr,
    input wire [7:0]  i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire [15:0] o_reg_rdata,
    input wire        o_shunt_span_sel,
    input wire        o_conv_start,
    input wire        o_conv_active,
    input wire [1:0]  o_conv_chan,
    input wire        o_result_update,
    input wire [15:0] o_shunt_volt_result
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    wire wr_dev  = i_reg_wr && i_reg_addr == 8'h00;
    wire wr_conv = i_reg_wr && i_reg_addr == 8'h01;

    property p_rsvd_zero;
        $past(i_reg_addr) == 8'h00 && $past(i_reg_addr, 2) == 8'h00
            |-> o_reg_rdata[15:14] == 2'h0 && !o_reg_rdata[5] && o_reg_rdata[3:0] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");
    property p_span;
        (wr_dev && !i_reg_wdata[15]) ##1 !i_reg_wr ##1 !i_reg_wr
            |=> o_shunt_span_sel == $past(i_reg_wdata[4], 3);
    endproperty
    a_span: assert property (p_span) else $error("span select not as written");
    property p_readback;
        wr_conv ##1 (!i_reg_wr && i_reg_addr == 8'h01)[*2] |=> o_reg_rdata == $past(i_reg_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("converter setup readback");
    property p_start_active;
        o_conv_start |-> o_conv_active && o_conv_chan != 2'h3;
    endproperty
    a_start_active: assert property (p_start_active) else $error("start outside a run");
    property p_update_pulse;
        o_result_update |=> !o_result_update;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update not a pulse");
    property p_res_update;
        $changed(o_shunt_volt_result) && o_shunt_volt_result != 16'h0000 |-> o_result_update;
    endproperty
    a_res_update: assert property (p_res_update) else $error("result without update");
    property p_shutdown;
        wr_conv && i_reg_wdata[14:12] == 3'h0 |-> ##3 !o_conv_start [*8];
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("conversion in shutdown");
    property p_soft_span;
        wr_dev && i_reg_wdata[15] |-> ##[3:4] !o_shunt_span_sel;
    endproperty
    a_soft_span: assert property (p_soft_span) else $error("soft reset kept span");
    property p_soft_start;
        wr_dev && i_reg_wdata[15] |-> ##[3:8] o_conv_start;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("no start after soft reset");
    c_update: cover property (o_result_update);
    c_soft: cover property (wr_dev && i_reg_wdata[15]);
    c_temp: cover property (o_conv_start && o_conv_chan == 2'h2);
endmodule // pmcs_top_sva

bind pmcs_top pmcs_top_sva #(
    .CYCLES_PER_US(CYCLES_PER_US), .DLY_STEP_CYCLES(DLY_STEP_CYCLES)
) u_sva (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_shunt_span_sel(o_shunt_span_sel),
    .o_conv_start(o_conv_start), .o_conv_active(o_conv_active), .o_conv_chan(o_conv_chan),
    .o_result_update(o_result_update), .o_shunt_volt_result(o_shunt_volt_result)
);

/* verification/pmcs_adc_model.sv */
// Converter front-end model giving pmcs_top per-channel samples
// Assumes the sample is taken in the last cycle of each conversion
module pmcs_adc_model #(
    parameter logic [15:0] BUS_BASE   = 16'h0100,
    parameter logic [15:0] SHUNT_BASE = 16'h0200,
    parameter logic [15:0] TEMP_BASE  = 16'h0300
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_conv_start,
    input  wire logic       i_conv_active,
    input  wire logic [1:0] i_conv_chan,
    output logic [15:0]     o_sample
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  flip;
    logic [15:0] level;

    // Each channel alternates base+4 and base, first sample of a run is base+4
    always @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n)
            flip <= 3'h0;
        else if (!i_conv_active)
            flip <= 3'h0;
        else if (i_conv_start)
            flip[i_conv_chan] <= ~flip[i_conv_chan];

    // Idle output shows the inverse, never the last value
    always_comb
    begin
        case (i_conv_chan)
            2'h0: level = BUS_BASE;
            2'h1: level = SHUNT_BASE;
            default: level = TEMP_BASE;
        endcase
        level = level + (flip[i_conv_chan] ? 16'h0004 : 16'h0000);
        o_sample = i_conv_active ? level : ~level;
    end
endmodule // pmcs_adc_model

/* verification/tb_top.sv */
// Self-checking bench for pmcs_top with a converter sample model
// Assumes a 4-cycle delay step and one cycle per microsecond
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          CPU = 1;
    localparam int          DLY = 4;
    localparam logic [15:0] BB  = 16'h1234;
    localparam logic [15:0] BS  = 16'hff38;
    localparam logic [15:0] BT  = 16'h0190;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr    = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] sample, rdata, res_b, res_s, res_t;
    logic        span, start, active, upd;
    logic [1:0]  chan;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t_wr;
    int          ct_us [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

    always #25 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    pmcs_top #(.CYCLES_PER_US(CPU), .DLY_STEP_CYCLES(DLY)) uut (
        .i_clock(clock), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_adc_sample(sample), .o_reg_rdata(rdata),
        .o_shunt_span_sel(span), .o_conv_start(start), .o_conv_active(active),
        .o_conv_chan(chan), .o_result_update(upd), .o_bus_volt_result(res_b),
        .o_shunt_volt_result(res_s), .o_temp_result(res_t)
    );
    pmcs_adc_model #(.BUS_BASE(BB), .SHUNT_BASE(BS), .TEMP_BASE(BT)) u_adc (
        .i_clock(clock), .i_rst_n(rst_n), .i_conv_start(start),
        .i_conv_active(active), .i_conv_chan(chan), .o_sample(sample)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        @(negedge clock);
        t_wr = cyc;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge clock);
        addr <= a;
        repeat (2) @(posedge clock);
        @(negedge clock);
        v = rdata;
    endtask

    task automatic wait_sig(input bit want_upd);
        int n;
        n = 0;
        do
            @(negedge clock) n++;
        while ((want_upd ? upd : start) !== 1'b1 && n < 6000);
        if ((want_upd ? upd : start) !== 1'b1)
        begin
            check(16'h0001, 16'h0000);
            summarize();
        end
    endtask

    task automatic expect_idle;
        int n;
        n = 0;
        repeat (2) @(negedge clock);
        repeat (100)
        begin
            @(negedge clock);
            if (start !== 1'b0)
                n++;
        end
        check(16'(n), 16'h0000);
    endtask

    // Writes a converter setup, follows its starts and checks results in triggered mode only
    task automatic run(input logic [15:0] conv, input int dly);
        int ctv[3];
        int shift[8];
        logic [15:0] got[3];
        logic [15:0] bases[3];
        int due, ch, r, rounds, last;
        shift = '{0, 2, 4, 6, 7, 8, 9, 10};
        bases = '{BB, BS, BT};
        ctv = '{ct_us[conv[11:9]] * CPU, ct_us[conv[8:6]] * CPU, ct_us[conv[5:3]] * CPU};
        rounds = (conv[15] ? 2 : 1) << shift[conv[2:0]];
        last = conv[14] ? 2 : (conv[13] ? 1 : 0);
        wr_reg(8'h01, conv);
        due = t_wr + 2 + dly * DLY;
        for (r = 0; r < rounds; r++)
            for (ch = 0; ch < 3; ch++)
                if (conv[12 + ch])
                begin
                    wait_sig(1'b0);
                    if (due >= 0)
                        check(16'(cyc - due), 16'h0000);
                    check({14'h0, chan}, 16'(ch));
                    due = (conv[15] && ch == last) ? -1 : cyc + ctv[ch];
                end
        if (!conv[15])
        begin
            wait_sig(1'b1);
            check(16'(cyc - due), 16'h0000);
            got = '{res_b, res_s, res_t};
            for (ch = 0; ch < 3; ch++)
                if (conv[12 + ch])
                    check(got[ch], bases[ch] + (conv[2:0] == 3'h0 ? 16'h4 : 16'h2));
        end
        else
            wr_reg(8'h01, {conv[12] ? 4'h8 : 4'h0, 12'h000});
        expect_idle();
    endtask

    task automatic test_regs;
        logic [15:0] v;
        rd_reg(8'h00, v);
        check(v, 16'h0000);
        rd_reg(8'h01, v);
        check(v, 16'hfb68);
        wr_reg(8'h00, 16'h7fff);
        rd_reg(8'h00, v);
        check(v, 16'h3fd0);
        check({15'h0, span}, 16'h0001);
        wr_reg(8'h05, 16'hffff);
        rd_reg(8'h05, v);
        check(v, 16'h0000);
        wr_reg(8'h01, 16'h8ff8);
        rd_reg(8'h01, v);
        check(v, 16'h8ff8);
        expect_idle();
        wr_reg(8'h00, 16'h0000);
        rd_reg(8'h00, v);
        check({15'h0, span}, 16'h0000);
    endtask

    task automatic test_modes;
        int m;
        for (m = 1; m < 16; m++)
            if (m != 8)
                run({m[3:0], 12'h000}, 0);
    endtask

    task automatic test_timing;
        int k;
        for (k = 0; k < 8; k++)
            run(16'h1000 | 16'(k << 9), 0);
        run(16'h7370, 0);
    endtask

    task automatic test_avg;
        int a;
        for (a = 0; a < 4; a++)
            run(16'h2000 | 16'(a), 0);
        run(16'h3001, 0);
    endtask

    task automatic test_delay;
        wr_reg(8'h00, 16'h00c0);
        run(16'h3000, 3);
        wr_reg(8'h00, 16'h3fc0);
        run(16'h1000, 255);
        wr_reg(8'h00, 16'h0000);
    endtask

    task automatic test_soft;
        logic [15:0] v;
        wr_reg(8'h00, 16'h0010);
        wr_reg(8'h00, 16'h8000);
        rd_reg(8'h00, v);
        check(v, 16'h0000);
        rd_reg(8'h01, v);
        check(v, 16'hfb68);
        check({15'h0, span}, 16'h0000);
        check(res_s, 16'h0000);
        check({15'h0, active}, 16'h0001);
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        test_regs();
        test_modes();
        test_timing();
        test_avg();
        test_delay();
        test_soft();
        summarize();
    end
endmodule // tb_top
